// ---- tlc_pkg.sv ----
// shared constants, types and pseudo-LRU helpers for the cache hierarchy
package tlc_pkg;

	// ==========================================================
	// geometry
	localparam int ADDR_W = 32;
	localparam int L1_BYTES = 8192;
	localparam int L1_WAYS = 4;
	localparam int L1_LINE = 64;
	localparam int L1_SETS = L1_BYTES / (L1_WAYS * L1_LINE);
	localparam int L1_OFS_W = 6;
	localparam int L1_IDX_W = 5;
	localparam int L1_TAG_W = ADDR_W - L1_OFS_W - L1_IDX_W;
	localparam int OPC_UOPS = 12288;
	localparam int OPC_WAYS = 8;
	localparam int OPC_UOPS_PER_LINE = 6;
	localparam int OPC_SETS = OPC_UOPS / (OPC_UOPS_PER_LINE * OPC_WAYS);
	localparam int OPC_OFS_W = 6;
	localparam int OPC_IDX_W = 8;
	localparam int OPC_TAG_W = ADDR_W - OPC_OFS_W - OPC_IDX_W;
	localparam int L2_BYTES = 262144;
	localparam int L2_WAYS = 8;
	localparam int L2_LINE = 128;
	localparam int L2_SECT_BYTES = 64;
	localparam int L2_SETS = L2_BYTES / (L2_WAYS * L2_LINE);
	localparam int L2_OFS_W = 7;
	localparam int L2_IDX_W = 8;
	localparam int L2_TAG_W = ADDR_W - L2_OFS_W - L2_IDX_W;
	localparam int L2_SECT_BIT = 6;
	localparam int INIT_LAST = 255;

	// ==========================================================
	// timing in core clocks, sector transfer time in bus clocks
	localparam logic [3:0] L1_INT_CYC = 4'h2;
	localparam logic [3:0] L1_FP_CYC = 4'h6;
	localparam logic [3:0] L2_CYC = 4'h7;
	localparam logic [3:0] OPC_HIT_CYC = 4'h2;
	localparam logic [7:0] MISS_CORE_CYC = 8'h0C;
	localparam int BUS_PUMP = 4;
	localparam int BUS_BEAT_BYTES = 8;
	localparam int SECTOR_BUS_CLKS = L2_SECT_BYTES / (BUS_BEAT_BYTES * BUS_PUMP);

	// ==========================================================
	// types
	typedef enum logic [1:0] {TLC_FETCH, TLC_LOAD_INT, TLC_LOAD_FP, TLC_STORE} tlc_kind_t;
	typedef enum logic [2:0] {
		ST_INIT, ST_IDLE, ST_LOOK, ST_WAIT, ST_ALIGN, ST_BUS, ST_RET, ST_RESP
	} tlc_state_t;
	typedef struct packed {
		logic [L1_TAG_W-1:0] tag;
		logic valid;
	} tlc_l1_way_t;
	typedef struct packed {
		logic [2:0] plru;
		tlc_l1_way_t [L1_WAYS-1:0] way;
	} tlc_l1_row_t;
	typedef struct packed {
		logic [OPC_TAG_W-1:0] tag;
		logic valid;
	} tlc_opc_way_t;
	typedef struct packed {
		logic [6:0] plru;
		tlc_opc_way_t [OPC_WAYS-1:0] way;
	} tlc_opc_row_t;
	typedef struct packed {
		logic [L2_TAG_W-1:0] tag;
		logic [1:0] sv;
		logic [1:0] sd;
	} tlc_l2_way_t;
	typedef struct packed {
		logic [6:0] plru;
		tlc_l2_way_t [L2_WAYS-1:0] way;
	} tlc_l2_row_t;

	// ==========================================================
	// pseudo-LRU tree: heap order, bit points toward the older half
	function automatic logic [2:0] tlc_plru_pick(input logic [6:0] tree, input int levels);
		int node;
		logic [2:0] way;
		node = 0;
		way = 3'h0;
		for (int lv = 0; lv < 3; lv++) begin
			if (lv < levels) begin
				way = {way[1:0], tree[node]};
				node = 2 * node + 1 + int'(tree[node]);
			end
		end
		return way;
	endfunction : tlc_plru_pick

	function automatic logic [6:0] tlc_plru_touch(input logic [6:0] tree, input logic [2:0] way,
		input int levels);
		int node;
		logic dir;
		logic [6:0] t;
		t = tree;
		node = 0;
		for (int lv = 0; lv < 3; lv++) begin
			if (lv < levels) begin
				dir = way[levels-1-lv];
				t[node] = ~dir;
				node = 2 * node + 1 + int'(dir);
			end
		end
		return t;
	endfunction : tlc_plru_touch

endpackage : tlc_pkg

// ---- tlc_ram_if.sv ----
// port bundle between the controller and one tag array
`timescale 1ns/100ps
interface tlc_ram_if #(parameter int W = 8, parameter int AW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tlc_ram_if

// ---- tlc_ram.sv ----
// simple dual-port tag array with registered read data
`timescale 1ns/100ps
module tlc_ram #(parameter int W = 8, parameter int AW = 8) (
	input wire logic sys_clk,
	tlc_ram_if.mem port
);
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [W-1:0] rd;

	always_ff @(posedge sys_clk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
		rd <= mem[port.raddr];
	end

	assign port.rdata = rd;
endmodule : tlc_ram

// ---- tlc_cache_hier.sv ----
// two-level cache hierarchy controller: tags, replacement, latency and bus miss path
// Behaviour
// RL1 - separate decoded-op and data arrays at first level
// RL2 - second level serves fetches and data alike
// RL3 - no inclusion enforced between levels
// RL4 - pseudo-LRU victim choice at every level
// RL5 - data cache 8KB/4way/64B, 2 or 6 clocks
// RL6 - decoded-op cache 12K ops, 8 ways
// RL7 - second level 256KB/8way/128B lines
// RL8 - second level write-back, 7 clock hits
// RL9 - two 64-byte sectors per second-level line
// RL10 - second-level miss starts a system bus transaction
// RL11 - bus moves four transfers per bus clock
// RL12 - miss adds 12 core cycles plus bus time
// RL13 - bus ratio converts bus cycles to core
// RL14 - every store also goes to second level
// RL15 - per-sector valid, fill leaves other invalid
// RL16 - tree PLRU updated on hits and fills
`timescale 1ns/100ps
module tlc_cache_hier
	import tlc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] bus_ratio,
	input wire logic req_valid,
	output logic req_ready,
	input tlc_kind_t req_kind,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic rsp_valid,
	output logic [1:0] rsp_level,
	output logic bus_req_valid,
	output logic bus_req_write,
	output logic [ADDR_W-1:0] bus_req_addr,
	input wire logic bus_done,
	output logic bus_tick,
	output logic [7:0] bus_cycles
);

	// ==========================================================
	// state
	typedef struct packed {
		tlc_state_t st;
		logic [7:0] cnt;
		logic [3:0] target;
		tlc_kind_t kind;
		logic [ADDR_W-1:0] addr;
		tlc_l1_row_t l1;
		tlc_opc_row_t op;
		tlc_l2_row_t l2;
		logic [2:0] l2way;
		logic wb;
		logic [7:0] init_idx;
		logic [3:0] div;
		logic tick;
		logic [7:0] bus_cyc;
		logic [1:0] level;
	} tlc_regs_t;

	tlc_regs_t r;
	tlc_regs_t n;

	// ==========================================================
	// tag arrays, one per cache
	tlc_ram_if #(.W($bits(tlc_l1_row_t)), .AW(L1_IDX_W)) l1_bus ();
	tlc_ram_if #(.W($bits(tlc_opc_row_t)), .AW(OPC_IDX_W)) op_bus ();
	tlc_ram_if #(.W($bits(tlc_l2_row_t)), .AW(L2_IDX_W)) l2_bus ();

	tlc_ram #(.W($bits(tlc_l1_row_t)), .AW(L1_IDX_W)) u_l1 (.sys_clk(sys_clk), .port(l1_bus)); // RL1 RL5
	tlc_ram #(.W($bits(tlc_opc_row_t)), .AW(OPC_IDX_W)) u_op (.sys_clk(sys_clk), .port(op_bus)); // RL1 RL6
	tlc_ram #(.W($bits(tlc_l2_row_t)), .AW(L2_IDX_W)) u_l2 (.sys_clk(sys_clk), .port(l2_bus)); // RL7

	// ==========================================================
	// lookup
	tlc_l1_row_t l1c;
	tlc_opc_row_t opc;
	tlc_l2_row_t l2c;
	tlc_l1_row_t l1w;
	tlc_opc_row_t opw;
	tlc_l2_row_t l2w;
	logic h1, ho, tm, h2, sect, wsect, upfill, is_load;
	logic [1:0] w1;
	logic [2:0] wo, w2, v1, vo, v2;
	logic [3:0] tgt, ratio_m1;
	logic [6:0] t7;
	logic [L2_TAG_W-1:0] tag2;

	assign l1c = (r.st == ST_LOOK) ? tlc_l1_row_t'(l1_bus.rdata) : r.l1;
	assign opc = (r.st == ST_LOOK) ? tlc_opc_row_t'(op_bus.rdata) : r.op;
	assign l2c = (r.st == ST_LOOK) ? tlc_l2_row_t'(l2_bus.rdata) : r.l2;
	assign sect = r.addr[L2_SECT_BIT];
	assign wsect = ~r.l2.way[r.l2way].sd[0];
	assign tag2 = r.addr[ADDR_W-1 -: L2_TAG_W];
	assign is_load = (r.kind == TLC_LOAD_INT) || (r.kind == TLC_LOAD_FP);
	assign ratio_m1 = (bus_ratio == 4'h0) ? 4'h0 : bus_ratio - 4'h1;

	always_comb begin
		h1 = 1'b0;
		w1 = 2'h0;
		ho = 1'b0;
		wo = 3'h0;
		tm = 1'b0;
		w2 = 3'h0;
		for (int i = 0; i < L1_WAYS; i++) begin
			if (l1c.way[i].valid && l1c.way[i].tag == r.addr[ADDR_W-1 -: L1_TAG_W]) begin
				h1 = 1'b1;
				w1 = 2'(i);
			end
		end
		for (int i = 0; i < OPC_WAYS; i++) begin
			if (opc.way[i].valid && opc.way[i].tag == r.addr[ADDR_W-1 -: OPC_TAG_W]) begin
				ho = 1'b1;
				wo = 3'(i);
			end
		end
		for (int i = 0; i < L2_WAYS; i++) begin
			if ((|l2c.way[i].sv) && l2c.way[i].tag == tag2) begin
				tm = 1'b1;
				w2 = 3'(i);
			end
		end
		h2 = tm && l2c.way[w2].sv[sect]; // RL9 RL15
		v1 = tlc_plru_pick({4'h0, l1c.plru}, 2); // RL4
		vo = tlc_plru_pick(opc.plru, 3); // RL4
		v2 = tm ? w2 : tlc_plru_pick(l2c.plru, 3); // RL4
	end

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		n.tick = 1'b0;
		l1w = l1c;
		opw = opc;
		l2w = l2c;
		upfill = 1'b0;
		tgt = L2_CYC;
		t7 = 7'h00;
		l1_bus.we = 1'b0;
		op_bus.we = 1'b0;
		l2_bus.we = 1'b0;
		l1_bus.raddr = req_addr[L1_OFS_W +: L1_IDX_W];
		op_bus.raddr = req_addr[OPC_OFS_W +: OPC_IDX_W];
		l2_bus.raddr = req_addr[L2_OFS_W +: L2_IDX_W];
		l1_bus.waddr = r.addr[L1_OFS_W +: L1_IDX_W];
		op_bus.waddr = r.addr[OPC_OFS_W +: OPC_IDX_W];
		l2_bus.waddr = r.addr[L2_OFS_W +: L2_IDX_W];
		// bus clock enable: one core tick in every bus_ratio
		if (r.div >= ratio_m1) begin // RL13
			n.div = 4'h0;
			n.tick = 1'b1;
		end else begin
			n.div = r.div + 4'h1;
		end
		unique case (r.st)
			ST_INIT: begin
				l1_bus.waddr = r.init_idx[L1_IDX_W-1:0];
				op_bus.waddr = r.init_idx;
				l2_bus.waddr = r.init_idx;
				l1_bus.we = 1'b1;
				op_bus.we = 1'b1;
				l2_bus.we = 1'b1;
				n.init_idx = r.init_idx + 8'h01;
				if (r.init_idx == 8'(INIT_LAST)) begin
					n.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (req_valid) begin
					n.addr = req_addr;
					n.kind = req_kind;
					n.st = ST_LOOK;
				end
			end
			ST_LOOK: begin
				n.l1 = l1c;
				n.op = opc;
				n.l2 = l2c;
				n.cnt = 8'h02;
				n.level = 2'h0;
				if (r.kind == TLC_FETCH && ho) begin
					opw.plru = tlc_plru_touch(opc.plru, wo, 3); // RL16
					op_bus.we = 1'b1;
					tgt = OPC_HIT_CYC;
				end else if (is_load && h1) begin
					t7 = tlc_plru_touch({4'h0, l1c.plru}, {1'b0, w1}, 2); // RL16
					l1w.plru = t7[2:0];
					l1_bus.we = 1'b1;
					tgt = (r.kind == TLC_LOAD_FP) ? L1_FP_CYC : L1_INT_CYC; // RL5
				end else begin
					// store hits refresh the line but leave no dirty state above
					if (r.kind == TLC_STORE && h1) begin // RL14
						t7 = tlc_plru_touch({4'h0, l1c.plru}, {1'b0, w1}, 2);
						l1w.plru = t7[2:0];
						l1_bus.we = 1'b1;
					end
					n.level = 2'h1;
					if (h2) begin // RL2
						l2w.plru = tlc_plru_touch(l2c.plru, w2, 3); // RL16
						if (r.kind == TLC_STORE) begin
							l2w.way[w2].sd[sect] = 1'b1; // RL8
						end
						l2_bus.we = 1'b1;
						upfill = 1'b1;
						tgt = L2_CYC; // RL8
					end else begin
						n.level = 2'h2;
						n.l2way = v2;
						n.wb = !tm && (|l2c.way[v2].sd); // RL8
					end
				end
				n.target = tgt;
				if (n.level == 2'h2) begin
					n.st = ST_ALIGN;
				end else if (tgt <= 4'h2) begin
					n.st = ST_RESP;
				end else begin
					n.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt + 8'h01 >= {4'h0, r.target}) begin
					n.st = ST_RESP;
				end
			end
			ST_ALIGN: begin
				// launch only on a bus clock boundary
				if (r.tick) begin // RL13
					n.bus_cyc = 8'h00;
					n.st = ST_BUS;
				end
			end
			ST_BUS: begin
				if (r.tick) begin
					n.bus_cyc = r.bus_cyc + 8'h01; // RL11 RL12
				end
				if (bus_done) begin // RL10
					if (r.wb) begin
						n.l2.way[r.l2way].sd[wsect] = 1'b0;
						n.wb = r.l2.way[r.l2way].sd[~wsect];
						n.st = ST_ALIGN;
					end else begin
						// evicted line stays wherever it sits above
						if (l2c.way[r.l2way].tag != tag2) begin // RL3
							l2w.way[r.l2way].sv = 2'h0; // RL15
							l2w.way[r.l2way].sd = 2'h0;
						end
						l2w.way[r.l2way].tag = tag2;
						l2w.way[r.l2way].sv[sect] = 1'b1; // RL9 RL15
						if (r.kind == TLC_STORE) begin
							l2w.way[r.l2way].sd[sect] = 1'b1;
						end
						l2w.plru = tlc_plru_touch(l2c.plru, r.l2way, 3); // RL16
						l2_bus.we = 1'b1;
						upfill = 1'b1;
						n.cnt = 8'h01;
						n.st = ST_RET;
					end
				end
			end
			ST_RET: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt >= MISS_CORE_CYC - 8'h01) begin // RL12
					n.st = ST_RESP;
				end
			end
			ST_RESP: begin
				n.st = ST_IDLE;
			end
		endcase
		// allocate fetches and loads in the first level without touching other levels
		if (upfill) begin // RL3
			if (r.kind == TLC_FETCH) begin
				opw.way[vo].tag = r.addr[ADDR_W-1 -: OPC_TAG_W];
				opw.way[vo].valid = 1'b1;
				opw.plru = tlc_plru_touch(opc.plru, vo, 3); // RL16
				op_bus.we = 1'b1;
			end else if (is_load) begin
				l1w.way[v1[1:0]].tag = r.addr[ADDR_W-1 -: L1_TAG_W];
				l1w.way[v1[1:0]].valid = 1'b1;
				t7 = tlc_plru_touch({4'h0, l1c.plru}, v1, 2); // RL16
				l1w.plru = t7[2:0];
				l1_bus.we = 1'b1;
			end
		end
		l1_bus.wdata = (r.st == ST_INIT) ? '0 : l1w;
		op_bus.wdata = (r.st == ST_INIT) ? '0 : opw;
		l2_bus.wdata = (r.st == ST_INIT) ? '0 : l2w;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '{st: ST_INIT, kind: TLC_FETCH, default: '0};
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// outputs
	assign req_ready = (r.st == ST_IDLE);
	assign rsp_valid = (r.st == ST_RESP);
	assign rsp_level = r.level;
	assign bus_req_valid = (r.st == ST_BUS);
	assign bus_req_write = r.wb;
	assign bus_req_addr = r.wb ?
		{r.l2.way[r.l2way].tag, r.addr[L2_OFS_W +: L2_IDX_W], wsect, 6'h00} :
		{r.addr[ADDR_W-1:L2_SECT_BIT], 6'h00};
	assign bus_tick = r.tick;
	assign bus_cycles = r.bus_cyc;

endmodule : tlc_cache_hier

// ---- tlc_bus_model.sv ----
// behavioural system bus responder for second-level miss traffic
`timescale 1ns/100ps
module tlc_bus_model #(parameter int MEM_TICKS = 6) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic bus_req_valid,
	input wire logic bus_tick,
	output logic bus_done
);
	logic [3:0] ticks;

	// ==========================================================
	// memory access time counted in bus clocks, one pulse per request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ticks <= 4'h0;
			bus_done <= 1'b0;
		end else begin
			bus_done <= 1'b0;
			if (!bus_req_valid || bus_done) begin
				ticks <= 4'h0;
			end else if (ticks == 4'(MEM_TICKS)) begin
				bus_done <= 1'b1;
			end else if (bus_tick) begin
				ticks <= ticks + 4'h1;
			end
		end
	end
endmodule : tlc_bus_model

// ---- tlc_cache_hier_assertions.sv ----
// port-level timing checks for the cache hierarchy
`timescale 1ns/100ps
module tlc_cache_hier_assertions
	import tlc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] bus_ratio,
	input wire logic req_valid,
	input wire logic req_ready,
	input tlc_kind_t req_kind,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic rsp_valid,
	input wire logic [1:0] rsp_level,
	input wire logic bus_req_valid,
	input wire logic bus_req_write,
	input wire logic [ADDR_W-1:0] bus_req_addr,
	input wire logic bus_done,
	input wire logic bus_tick,
	input wire logic [7:0] bus_cycles
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic [7:0] since_take;
	tlc_kind_t take_kind;
	logic [3:0] tick_gap;
	logic [3:0] ratio;
	assign ratio = (bus_ratio == 4'h0) ? 4'h1 : bus_ratio;

	// ==========================================================
	// helper counters
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			since_take <= 8'h00;
			take_kind <= TLC_FETCH;
			tick_gap <= 4'h0;
		end else begin
			tick_gap <= bus_tick ? 4'h1 : tick_gap + 4'h1;
			if (req_valid && req_ready) begin
				since_take <= 8'h01;
				take_kind <= req_kind;
			end else if (since_take != 8'hFF) begin
				since_take <= since_take + 8'h01;
			end
		end
	end

	// ==========================================================
	// sequences and properties
	sequence s_take(tlc_kind_t k);
		req_valid && req_ready && req_kind == k;
	endsequence
	sequence s_fill_done;
		bus_req_valid && bus_done && !bus_req_write;
	endsequence

	int_quiet_a: assert property (s_take(TLC_LOAD_INT) |=> !rsp_valid)
		else $error("int load answered too early");
	fp_quiet_a: assert property (s_take(TLC_LOAD_FP) |=> !rsp_valid [*5])
		else $error("fp load answered too early");
	store_quiet_a: assert property (s_take(TLC_STORE) |=> !rsp_valid [*6])
		else $error("store answered before second level");
	first_level_time_a: assert property (rsp_valid && rsp_level == 2'h0 |->
		since_take == ((take_kind == TLC_LOAD_FP) ? 8'h06 : 8'h02))
		else $error("first level hit latency wrong");
	second_level_time_a: assert property (rsp_valid && rsp_level == 2'h1 |-> since_take == 8'h07)
		else $error("second level hit latency wrong");
	miss_return_a: assert property (s_fill_done |-> ##12 (rsp_valid && rsp_level == 2'h2))
		else $error("miss answer not 12 cycles after fill");
	bus_release_a: assert property (bus_req_valid && bus_done |=> !bus_req_valid)
		else $error("bus request held after done");
	sector_addr_a: assert property (bus_req_valid |-> bus_req_addr[5:0] == 6'h00)
		else $error("bus address not sector aligned");
	bus_hold_a: assert property (bus_req_valid && $past(bus_req_valid) |->
		$stable(bus_req_addr) && $stable(bus_req_write))
		else $error("bus request changed while outstanding");
	bus_start_a: assert property ($rose(bus_req_valid) |-> $past(bus_tick))
		else $error("bus request not aligned to bus clock");
	tick_period_a: assert property (bus_tick |-> tick_gap == ratio)
		else $error("bus clock enable period wrong");
endmodule : tlc_cache_hier_assertions

bind tlc_cache_hier tlc_cache_hier_assertions u_chk (.sys_clk(sys_clk), .rst(rst),
	.bus_ratio(bus_ratio), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
	.req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_level(rsp_level),
	.bus_req_valid(bus_req_valid), .bus_req_write(bus_req_write), .bus_req_addr(bus_req_addr),
	.bus_done(bus_done), .bus_tick(bus_tick), .bus_cycles(bus_cycles));

// ---- tlc_cache_hier_test.sv ----
// self-checking testbench for the cache hierarchy
`timescale 1ns/100ps
module tlc_cache_hier_test;
	import tlc_pkg::*;

	localparam logic [31:0] A = 32'h0000_1000;
	localparam logic [31:0] B = 32'h0004_0000;
	localparam logic [31:0] C = 32'h0000_2200;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] bus_ratio = 4'h3;
	logic req_valid = 1'b0;
	tlc_kind_t req_kind = TLC_FETCH;
	logic [31:0] req_addr = 32'h0;
	logic req_ready, rsp_valid, bus_req_valid, bus_req_write, bus_done, bus_tick;
	logic [1:0] rsp_level, lvl;
	logic [31:0] bus_req_addr, fill_addr, wb_addr;
	logic [7:0] bus_cycles;
	logic wb_seen = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	int lat;

	tlc_cache_hier dut (.sys_clk(sys_clk), .rst(rst), .bus_ratio(bus_ratio),
		.req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
		.rsp_valid(rsp_valid), .rsp_level(rsp_level), .bus_req_valid(bus_req_valid),
		.bus_req_write(bus_req_write), .bus_req_addr(bus_req_addr), .bus_done(bus_done),
		.bus_tick(bus_tick), .bus_cycles(bus_cycles));
	tlc_bus_model u_bus (.sys_clk(sys_clk), .rst(rst), .bus_req_valid(bus_req_valid),
		.bus_tick(bus_tick), .bus_done(bus_done));

	always #10 sys_clk = ~sys_clk;

	// ==========================================================
	// shared tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task close_out;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task access(input tlc_kind_t k, input logic [31:0] a);
		int i;
		for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge sys_clk);
		if (req_ready !== 1'b1) begin
			n_errors++;
			close_out();
		end
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_addr <= a;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		lat = 0;
		fill_addr = 32'hFFFF_FFFF;
		for (i = 1; i <= 3000 && lat == 0; i++) begin
			@(negedge sys_clk);
			if (bus_req_valid === 1'b1 && bus_req_write === 1'b0) fill_addr = bus_req_addr;
			if (bus_req_valid === 1'b1 && bus_req_write === 1'b1) begin
				wb_seen = 1'b1;
				wb_addr = bus_req_addr;
			end
			if (rsp_valid === 1'b1) begin
				lat = i;
				lvl = rsp_level;
			end
		end
		if (lat == 0) begin
			n_errors++;
			close_out();
		end
	endtask : access

	// exp_lat of 0: miss, latency set by the bus
	task expect_rsp(input tlc_kind_t k, input logic [31:0] a, input logic [1:0] exp_lvl,
		input int exp_lat);
		access(k, a);
		check({30'h0, lvl}, {30'h0, exp_lvl});
		if (exp_lat != 0) check(32'(lat), 32'(exp_lat));
		if (exp_lvl == 2'h2) check(fill_addr, {a[31:6], 6'h00});
	endtask : expect_rsp

	// ==========================================================
	// scenarios
	task t_fill;
		expect_rsp(TLC_LOAD_INT, A, 2'h2, 0);
		check({24'h0, bus_cycles}, 32'h6);
		expect_rsp(TLC_LOAD_INT, A, 2'h0, 2);
		expect_rsp(TLC_LOAD_FP, A + 32'h8, 2'h0, 6);
		$display("fill test done");
	endtask : t_fill

	task t_store;
		expect_rsp(TLC_STORE, A, 2'h1, 7);
		expect_rsp(TLC_STORE, C, 2'h2, 0);
		expect_rsp(TLC_LOAD_INT, C, 2'h1, 7);
		$display("store test done");
	endtask : t_store

	task t_sector;
		expect_rsp(TLC_LOAD_INT, A + 32'h40, 2'h2, 0);
		expect_rsp(TLC_LOAD_INT, A + 32'h40, 2'h0, 2);
		$display("sector test done");
	endtask : t_sector

	task t_fetch;
		expect_rsp(TLC_FETCH, B, 2'h2, 0);
		expect_rsp(TLC_FETCH, B, 2'h0, 2);
		expect_rsp(TLC_LOAD_INT, B, 2'h1, 7);
		$display("fetch test done");
	endtask : t_fetch

	task t_evict;
		wb_seen = 1'b0;
		wb_addr = 32'h0;
		for (int k = 1; k <= 8; k++) expect_rsp(TLC_LOAD_INT, C + k * 32'h8000, 2'h2, 0);
		check({31'h0, wb_seen}, 32'h1);
		check(wb_addr, {C[31:6], 6'h00});
		$display("evict test done");
	endtask : t_evict

	// reset in mid-run with another bus ratio: tags cleared, tick period follows ratio
	task t_ratio;
		int i;
		int gap;
		@(posedge sys_clk);
		rst <= 1'b1;
		bus_ratio <= 4'h2;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		expect_rsp(TLC_LOAD_FP, A, 2'h2, 0);
		expect_rsp(TLC_LOAD_FP, A, 2'h0, 6);
		for (i = 0; i < 8 && bus_tick !== 1'b1; i++) @(negedge sys_clk);
		gap = 0;
		do begin
			@(negedge sys_clk);
			gap++;
		end while (bus_tick !== 1'b1 && gap < 8);
		check(32'(gap), 32'h2);
		$display("ratio test done");
	endtask : t_ratio

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		t_fill();
		t_store();
		t_sector();
		t_fetch();
		t_evict();
		t_ratio();
		close_out();
	end
endmodule : tlc_cache_hier_test
